// File: rtl/sacc_defs.vh
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH
// register byte offsets
`define SACC_OFF_CTRL    12'h000
`define SACC_OFF_POS     12'h004
`define SACC_OFF_NEG     12'h008
`define SACC_OFF_STAT    12'h00C
`define SACC_OFF_RESULT  12'h010
`define SACC_OFF_GAIN    12'h014
// control register fields
`define SACC_CTL_ENABLE  0
`define SACC_CTL_MODE_LO 1
`define SACC_CTL_MODE_HI 2
`define SACC_CTL_CONV_LO 3
`define SACC_CTL_CONV_HI 5
`define SACC_CTL_NEGBYP  14
`define SACC_CTL_POSBYP  15
`define SACC_CTL_PAIRBUF 16
`define SACC_CTL_RESET   32'h0000_0000
// input configurations
`define SACC_MODE_DIFF   2'h0
`define SACC_MODE_SINGLE 2'h1
`define SACC_MODE_PSEUDO 2'h2
// conversion types
`define SACC_CONV_PIN    3'h0
`define SACC_CONV_TMR0   3'h1
`define SACC_CONV_TMR1   3'h2
`define SACC_CONV_SINGLE 3'h3
`define SACC_CONV_CONT   3'h4
`define SACC_CONV_PLA    3'h5
`define SACC_CONV_IDLE   3'h6
// status and result fields
`define SACC_STA_READY   0
`define SACC_STA_BUSY    1
`define SACC_RES_LSB     16
// gain field widths and reset value (1 to 5 in 32 steps)
`define SACC_GAIN_W      5
`define SACC_GAIN_RESET  5'h00
// channel select
`define SACC_CHAN_W      5
`define SACC_NEG_W       5
// conversion time in clocks
`define SACC_CONV_CLKS   27
`endif

// File: rtl/sacc_result_store.v
/*
 result holding register: latches the 12-bit coded word on load.
 assumes load is a one-cycle pulse from the conversion sequencer.
*/
`timescale 1ns/100ps
`include "sacc_defs.vh"
module sacc_result_store #(
  parameter WIDTH = 12
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             load,
  input  wire [WIDTH-1:0] dataIn,
  output reg  [WIDTH-1:0] dataOut
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOut <= {WIDTH{1'b0}};
    end else if (load) begin
      dataOut <= dataIn;
    end
  end
endmodule

// File: rtl/sacc_conversion_control.v
/*
 conversion control for a 12-bit successive-approximation converter:
 apb register file, trigger selection, conversion sequencer, result coding.
 assumes the analog side returns a raw 12-bit code with rawValid after each
 conversion, and trigger inputs other than timers/logic array are async pins.

 // Summary of operation
 // R1: software picks fully differential, single-ended or pseudo-differential input.
 // R2: software starts one conversion or continuous back-to-back conversions.
 // R3: pin, logic array output, or either timer overflow may trigger repeatedly.
 // R4: a trigger still high at conversion end starts another conversion.
 // R5: single-ended and pseudo-differential results are straight binary, 4096 codes.
 // R6: fully differential results are twos complement over 4096 codes.
 // R7: differential result is sign plus eleven bits, shifted right one bit.
 // R8: control bit 14 disables both amplified-pair negative pin buffers.
 // R9: each amplified pair has a 5-bit gain field, 32 steps.
 // R10: software uses pseudo-differential mode for amplified pairs.
 // R11: software follows the fixed amplified-pair setup order.
 // R12: buffer, converter and channel settings are independent controls.
 // R13: positive select offers supply, current-output, temperature, reference, ground inputs.
 // R14: negative select offers analog, power or I/O ground for internal inputs.
 // R15: software enables the input buffer for current-output and supply channels.
 // R16: software bypasses negative buffer and uses pseudo mode for thermistors.
 // R17: ready flag bit 0 sets at conversion end; result read clears it.
 // R18: result sits in bits 27:16, top four bits sign extension.
 // R19: control bits 15 and 14 bypass positive and negative buffers.
 // R20: triggers ignored during conversion; busy high throughout.
 // R21: continuous mode restarts right after result latch until mode cleared.
*/
`timescale 1ns/100ps
`include "sacc_defs.vh"
module sacc_conversion_control #(
  parameter CONV_CLKS = `SACC_CONV_CLKS
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        convert_start_pin,
  input  wire        programmable_logic_array,
  input  wire        first_timer,
  input  wire        second_timer,
  input  wire [11:0] rawCode,
  input  wire        rawValid,
  output reg         sampleStart,
  output reg         converterBusy,
  output wire [1:0]  inputMode,
  output wire [4:0]  positiveChannel,
  output wire [4:0]  negativeChannel,
  output wire        posBufferBypass,
  output wire        negBufferBypass,
  output wire        pairNegBufferOff,
  output wire        pairZeroSelect,
  output wire [4:0]  gainPairZero,
  output wire [4:0]  gainPairOne
);
  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_DONE = 2'b10;

  reg  [31:0] converter_control_reg;
  reg  [4:0]  positive_channel_select;
  reg  [4:0]  negative_channel_select;
  reg  [9:0]  gainReg;
  reg         result_ready_flag;
  reg  [1:0]  state;
  reg  [7:0]  convCount;
  reg         swStart;
  reg         trigPrev;
  reg  [2:0]  pinSync;
  reg         pinLevel;
  reg  [1:0]  convMode;
  wire [11:0] storedCode;
  wire [11:0] codedResult;
  wire        wrEn;
  wire        rdEn;
  wire        enable;
  wire [2:0]  convType;
  wire        hwTrig;
  wire        hwSource;
  wire        contMode;
  wire        startReq;
  wire        convDone;
  wire        latchResult;

  // ----------------------------------------------------------------
  // apb slave: zero wait states, unmapped addresses read zero, no error
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & penable & ~pwrite;

  // extend the 12-bit code into the top of the result word, with sign bits only when signedCode is set
  function [31:0] resultWord;
    input [11:0] code;
    input        signedCode;
    begin
      resultWord = {{4{signedCode & code[11]}}, code, 16'h0000};  // R18
    end
  endfunction

  // ----------------------------------------------------------------
  // register writes, one process per register except the two channel selects, which share one
  // ----------------------------------------------------------------
  // separate processes keep a write to one register from touching another
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_control_reg <= `SACC_CTL_RESET;
      swStart               <= 1'b0;
    end else begin
      swStart <= 1'b0;
      if (wrEn && paddr == `SACC_OFF_CTRL) begin
        converter_control_reg <= pwdata;  // R1 R12 R19
        swStart <= (pwdata[`SACC_CTL_CONV_HI:`SACC_CTL_CONV_LO] == `SACC_CONV_SINGLE); // R2
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      positive_channel_select <= 5'h00;
      negative_channel_select <= 5'h00;
    end else if (wrEn) begin
      if (paddr == `SACC_OFF_POS) begin
        positive_channel_select <= pwdata[4:0];  // R13
      end
      if (paddr == `SACC_OFF_NEG) begin
        negative_channel_select <= pwdata[4:0];  // R14
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gainReg <= {`SACC_GAIN_RESET, `SACC_GAIN_RESET};
    end else if (wrEn && paddr == `SACC_OFF_GAIN) begin
      gainReg <= {pwdata[12:8], pwdata[4:0]};  // R9
    end
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always @* begin
    case (paddr)
      `SACC_OFF_CTRL:   prdata = converter_control_reg;
      `SACC_OFF_POS:    prdata = {27'h000_0000, positive_channel_select};
      `SACC_OFF_NEG:    prdata = {27'h000_0000, negative_channel_select};
      `SACC_OFF_STAT:   prdata = {30'h0000_0000, converterBusy, result_ready_flag};
      `SACC_OFF_RESULT: prdata = resultWord(storedCode, convMode == `SACC_MODE_DIFF);
      `SACC_OFF_GAIN:   prdata = {19'h0_0000, gainReg[9:5], 3'h0, gainReg[4:0]};
      default:          prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign enable           = converter_control_reg[`SACC_CTL_ENABLE];
  assign inputMode        = converter_control_reg[`SACC_CTL_MODE_HI:`SACC_CTL_MODE_LO]; // R1
  assign convType         = converter_control_reg[`SACC_CTL_CONV_HI:`SACC_CTL_CONV_LO];
  assign posBufferBypass  = converter_control_reg[`SACC_CTL_POSBYP];  // R19
  assign negBufferBypass  = converter_control_reg[`SACC_CTL_NEGBYP];  // R19
  assign pairNegBufferOff = converter_control_reg[`SACC_CTL_NEGBYP];  // R8
  assign pairZeroSelect   = converter_control_reg[`SACC_CTL_PAIRBUF];
  assign positiveChannel  = positive_channel_select;
  assign negativeChannel  = negative_channel_select;
  assign gainPairZero     = gainReg[4:0];
  assign gainPairOne      = gainReg[9:5];

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  // pin is asynchronous: three stages, level changes only when 2nd and 3rd agree
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinSync  <= 3'b000;
      pinLevel <= 1'b0;
    end else begin
      pinSync <= {pinSync[1:0], convert_start_pin};
      if (pinSync[1] == pinSync[2]) begin
        pinLevel <= pinSync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // source selection and edge detection
  // ----------------------------------------------------------------
  // one source at a time; software modes and idle give no hardware edge
  function pickSource;
    input [2:0] kind;
    input       pinLvl;
    input       plaOut;
    input       tmrZero;
    input       tmrOne;
    begin
      case (kind)
        `SACC_CONV_PIN:  pickSource = pinLvl;
        `SACC_CONV_TMR0: pickSource = tmrZero;
        `SACC_CONV_TMR1: pickSource = tmrOne;
        `SACC_CONV_PLA:  pickSource = plaOut;
        default:         pickSource = 1'b0;
      endcase
    end
  endfunction

  assign hwSource = pickSource(convType, pinLevel, programmable_logic_array,
                               first_timer, second_timer);  // R3
  // edge only: a level held through a conversion is handled by the repeat path
  assign hwTrig   = hwSource & ~trigPrev;  // R3
  assign contMode = (convType == `SACC_CONV_CONT);
  assign startReq = enable & (swStart | hwTrig | contMode);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= hwSource;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // rawValid ends a conversion early; otherwise the count bounds it so a
  // silent analog side cannot hang the block
  assign convDone = rawValid || (convCount == CONV_CLKS[7:0] - 8'h01);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= ST_IDLE;
      convCount     <= 8'h00;
      sampleStart   <= 1'b0;
      converterBusy <= 1'b0;
      convMode      <= `SACC_MODE_DIFF;
    end else begin
      sampleStart <= 1'b0;
      case (state)
        ST_IDLE: begin
          // start requests are only looked at while idle
          if (startReq) begin
            state         <= ST_CONV;
            convCount     <= 8'h00;
            sampleStart   <= 1'b1;
            converterBusy <= 1'b1;  // R20
            convMode      <= inputMode;
          end
        end
        ST_CONV: begin
          convCount <= convCount + 8'h01;
          if (convDone) begin
            state <= ST_DONE;  // R20
          end
        end
        ST_DONE: begin
          // repeat if trigger still held, or continuous still selected
          if (enable && (contMode || hwSource)) begin  // R4 R21
            state       <= ST_CONV;
            convCount   <= 8'h00;
            sampleStart <= 1'b1;
            convMode    <= inputMode;
          end else begin
            state         <= ST_IDLE;
            converterBusy <= 1'b0;
          end
        end
        default: begin
          state         <= ST_IDLE;
          converterBusy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result coding and ready flag
  // ----------------------------------------------------------------
  // differential: sign + 11 bits shifted right one, keeping the sign bit
  // non-differential modes pass the raw code as straight binary
  function [11:0] codeResult;
    input [11:0] raw;
    input [1:0]  mode;
    begin
      case (mode)
        `SACC_MODE_DIFF:   codeResult = {raw[11], raw[11:1]};  // R6 R7
        `SACC_MODE_SINGLE: codeResult = raw;                   // R5
        `SACC_MODE_PSEUDO: codeResult = raw;                   // R5
        default:           codeResult = raw;
      endcase
    end
  endfunction

  assign codedResult = codeResult(rawCode, convMode);
  assign latchResult = (state == ST_CONV) && convDone;

  // ----------------------------------------------------------------
  // result store
  // ----------------------------------------------------------------
  sacc_result_store #(
    .WIDTH(12)
  ) sacc_result_store_inst (
    .clk    (clk),
    .rst_b  (rst_b),
    .load   (latchResult),
    .dataIn (codedResult),
    .dataOut(storedCode)
  );

  // ----------------------------------------------------------------
  // ready flag
  // ----------------------------------------------------------------
  // set wins over a same-cycle read clear
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_ready_flag <= 1'b0;
    end else if (latchResult) begin
      result_ready_flag <= 1'b1;  // R17
    end else if (rdEn && paddr == `SACC_OFF_RESULT) begin
      result_ready_flag <= 1'b0;  // R17
    end
  end
endmodule

// File: verification/sacc_conversion_chk.sv
/* checker: port relations of the conversion control block.
   assumes a bind into sacc_conversion_control, one clock domain. */
`timescale 1ns/100ps
`include "sacc_defs.vh"
module sacc_conversion_chk (
  input wire        clk,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        sampleStart,
  input wire        converterBusy,
  input wire [1:0]  inputMode,
  input wire        posBufferBypass,
  input wire        negBufferBypass,
  input wire        pairNegBufferOff,
  input wire [4:0]  gainPairZero
);
  // ------------------
  // assertions
  // ------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire ctlWr  = psel && penable && pwrite && paddr == `SACC_OFF_CTRL;
  wire gainWr = psel && penable && pwrite && paddr == `SACC_OFF_GAIN;
  wire resRd  = psel && !pwrite && paddr == `SACC_OFF_RESULT;
  mode_write_a: assert property (ctlWr |=> inputMode == $past(pwdata[2:1]))
    else $error("input mode differs from control write");
  bypass_write_a: assert property (ctlWr |=> posBufferBypass == $past(pwdata[15])
    && negBufferBypass == $past(pwdata[14])) else $error("bypass differs from write");
  pair_buffer_a: assert property (pairNegBufferOff == negBufferBypass)
    else $error("pair buffer not tied to negative bypass");
  gain_write_a: assert property (gainWr |=>
    gainPairZero == $past(pwdata[4:0]) && $stable(inputMode)) else $error("gain write bad");
  start_busy_a: assert property (sampleStart |-> converterBusy)
    else $error("start without busy");
  start_pulse_a: assert property (sampleStart |=> !sampleStart)
    else $error("start longer than one cycle");
  busy_rise_a: assert property ($rose(converterBusy) |-> sampleStart)
    else $error("busy rose without a start");
  result_word_a: assert property (resRd |-> prdata[15:0] == 16'h0000 &&
    (prdata[31:28] == 4'h0 || prdata[31:28] == {4{prdata[27]}})) else $error("result layout");
endmodule

bind sacc_conversion_control sacc_conversion_chk sacc_conversion_chk_inst (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sampleStart(sampleStart),
  .converterBusy(converterBusy), .inputMode(inputMode), .posBufferBypass(posBufferBypass),
  .negBufferBypass(negBufferBypass), .pairNegBufferOff(pairNegBufferOff),
  .gainPairZero(gainPairZero));

// File: verification/sacc_analog_model.sv
/* analog side model: answers each sample start with a code and a strobe.
   assumes the bench sets nextCode and lag before the start. */
`timescale 1ns/100ps
module sacc_analog_model (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        sampleStart,
  input  wire [11:0] nextCode,
  input  wire [3:0]  lag,
  output reg  [11:0] rawCode,
  output reg         rawValid
);
  // ------------------
  // answer timing
  // ------------------
  reg [4:0] count;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count    <= 5'h00;
      rawValid <= 1'b0;
      rawCode  <= 12'h000;
    end else begin
      // toggles off the strobe so a stale code never looks valid
      rawCode  <= (sampleStart || count != 5'h01) ? ~rawCode : nextCode;
      rawValid <= !sampleStart && count == 5'h01;
      if (sampleStart)
        count <= {1'b0, lag} + 5'h01;
      else if (count != 5'h00)
        count <= count - 5'h01;
    end
  end
endmodule

// File: verification/sacc_conversion_control_tb.sv
/* bench: register and conversion scenarios for sacc_conversion_control.
   assumes sacc_analog_model on the raw side and the bound checker. */
`timescale 1ns/100ps
`include "sacc_defs.vh"
module sacc_conversion_control_tb;
  reg         clk, rst_b, psel, penable, pwrite;
  reg  [11:0] paddr, nextCode;
  reg  [31:0] pwdata, rd;
  reg  [3:0]  trig, lag;
  wire [31:0] prdata;
  wire [11:0] rawCode;
  wire [4:0]  posChan, negChan, gain0, gain1;
  wire [1:0]  inputMode;
  wire        pready, rawValid, sampleStart, busy, posByp, negByp, pairOff, pairSel;
  integer     errors, checks, starts, base, n;
  sacc_conversion_control #(.CONV_CLKS(8)) sacc_conversion_control_inst (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(),
    .convert_start_pin(trig[0]), .programmable_logic_array(trig[1]),
    .first_timer(trig[2]), .second_timer(trig[3]), .rawCode(rawCode), .rawValid(rawValid),
    .sampleStart(sampleStart), .converterBusy(busy), .inputMode(inputMode),
    .positiveChannel(posChan), .negativeChannel(negChan), .posBufferBypass(posByp),
    .negBufferBypass(negByp), .pairNegBufferOff(pairOff), .pairZeroSelect(pairSel),
    .gainPairZero(gain0), .gainPairOne(gain1));
  sacc_analog_model sacc_analog_model_inst (.clk(clk), .rst_b(rst_b),
    .sampleStart(sampleStart), .nextCode(nextCode), .lag(lag), .rawCode(rawCode),
    .rawValid(rawValid));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (sampleStart === 1'b1) starts <= starts + 1;
  // ------------------
  // tasks
  // ------------------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  function [31:0] ctl(input [1:0] m, input [2:0] c, input [31:0] x);
    ctl = x | {26'h000_0000, c, m, 1'b1};
  endfunction
  task t_regs;
    begin
      apb(`SACC_OFF_CTRL, 1'b0, 32'h0000_0000);
      chk(rd, `SACC_CTL_RESET);
      apb(`SACC_OFF_GAIN, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(12'h040, 1'b1, 32'hFFFF_FFFF);
      apb(12'h040, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
  endtask
  task t_cfg;
    begin
      for (n = 0; n < 3; n = n + 1) begin
        apb(`SACC_OFF_CTRL, 1'b1, ctl(n[1:0], `SACC_CONV_IDLE, 32'h0001_8000));
        chk({inputMode, posByp, negByp, pairOff, pairSel}, {n[1:0], 4'b1001});
      end
      apb(`SACC_OFF_POS, 1'b1, 32'h0000_001F);
      apb(`SACC_OFF_NEG, 1'b1, 32'h0000_0012);
      apb(`SACC_OFF_GAIN, 1'b1, 32'h0000_1F15);
      chk({posChan, negChan, gain1, gain0, inputMode}, {20'hF_CBF5, 2'h2});
      apb(`SACC_OFF_CTRL, 1'b1, ctl(2'h2, `SACC_CONV_IDLE, 32'h0000_4000));
      chk({posByp, negByp, pairOff}, 3'b011);
      apb(`SACC_OFF_CTRL, 1'b0, 32'h0000_0000);
      chk(rd, ctl(2'h2, `SACC_CONV_IDLE, 32'h0000_4000));
    end
  endtask
  task t_single(input [1:0] m, input [11:0] code, input [31:0] exp);
    begin
      nextCode <= code;
      apb(`SACC_OFF_CTRL, 1'b1, ctl(m, `SACC_CONV_SINGLE, 32'h0000_0000));
      rd = 32'h0000_0000;
      for (n = 0; n < 40 && rd[0] !== 1'b1; n = n + 1) apb(`SACC_OFF_STAT, 1'b0, 32'h0000_0000);
      chk(rd[0], 1'b1);
      apb(`SACC_OFF_RESULT, 1'b0, 32'h0000_0000);
      chk(rd, exp);
      apb(`SACC_OFF_STAT, 1'b0, 32'h0000_0000);
      chk(rd[0], 1'b0);
    end
  endtask
  task t_trig(input [1:0] s, input [2:0] c);
    begin
      apb(`SACC_OFF_CTRL, 1'b1, ctl(`SACC_MODE_SINGLE, c, 32'h0000_0000));
      base = starts;
      trig[s] <= 1'b1;
      repeat (2) @(posedge clk);
      trig[s] <= 1'b0;
      repeat (3) @(posedge clk);
      // second edge lands while the first conversion runs
      trig[s] <= 1'b1;
      repeat (2) @(posedge clk);
      trig[s] <= 1'b0;
      repeat (40) @(posedge clk);
      chk(starts - base, 32'h0000_0001);
      base = starts;
      trig[s] <= 1'b1;
      repeat (40) @(posedge clk);
      trig[s] <= 1'b0;
      chk(starts - base > 1, 1'b1);
      repeat (40) @(posedge clk);
      chk(busy, 1'b0);
    end
  endtask
  task t_cont;
    begin
      apb(`SACC_OFF_CTRL, 1'b1, ctl(`SACC_MODE_SINGLE, `SACC_CONV_CONT, 32'h0000_0000));
      base = starts;
      repeat (60) @(posedge clk);
      chk(starts - base > 2, 1'b1);
      apb(`SACC_OFF_CTRL, 1'b1, ctl(`SACC_MODE_SINGLE, `SACC_CONV_IDLE, 32'h0000_0000));
      repeat (30) @(posedge clk);
      base = starts;
      repeat (30) @(posedge clk);
      chk(busy, 1'b0);
      chk(starts - base, 32'h0000_0000);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ------------------
  // sequence
  // ------------------
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, nextCode, trig} = 0;
    {errors, checks, starts} = 0;
    lag = 4'h1;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_cfg;
    t_single(`SACC_MODE_SINGLE, 12'hABC, 32'h0ABC_0000);
    // answer well inside the eight-cycle window so the code, not a timeout, is kept
    lag <= 4'h3;
    t_single(`SACC_MODE_PSEUDO, 12'hFFF, 32'h0FFF_0000);
    t_single(`SACC_MODE_DIFF, 12'h9A5, 32'hFCD2_0000);
    t_single(`SACC_MODE_DIFF, 12'h5A4, 32'h02D2_0000);
    t_trig(2'h0, `SACC_CONV_PIN);
    t_trig(2'h1, `SACC_CONV_PLA);
    t_trig(2'h2, `SACC_CONV_TMR0);
    t_trig(2'h3, `SACC_CONV_TMR1);
    lag <= 4'h1;
    t_cont;
    finish_test;
  end
  initial begin
    #100000;
    errors = errors + 1;
    finish_test;
  end
endmodule
